// ==== rtl/lpd_consts.svh ====
// constants shared by both ends of the pixel link
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH

// ==================================================================
// link shape
`define LPD_LANES        3
`define LPD_SLOTS        7
`define LPD_WORD_W       21
`define LPD_COLOR_W      6
`define LPD_LANE_IDX_W   2
`define LPD_SLOT_IDX_W   3
`define LPD_BIT_IDX_W    5

// ==================================================================
// timing at the 10 MHz system clock
`define LPD_CLK_MHZ      10
`define LPD_SLOT_CYC     2
`define LPD_CLK_HI_SLOTS 4
`define LPD_PER_MIN      14
`define LPD_PER_MAX      28
`define LPD_CNT_W        8
`define LPD_ACC_W        12
`define LPD_ACC_STEP     (2 * `LPD_SLOTS)
`define LPD_LOCK_EDGES   4
`define LPD_LOCK_TIME_MS 10
`define LPD_LOCK_CYC     (`LPD_LOCK_TIME_MS * 1000 * `LPD_CLK_MHZ)
`define LPD_PDN_TIME_US  1
`define LPD_PDN_CYC      (`LPD_PDN_TIME_US * `LPD_CLK_MHZ)

`endif

// ==== rtl/lpd_pkg.sv ====
// types and the shared lane/slot bit map of the pixel link
`include "lpd_consts.svh"

package lpd_pkg;

    // ==================================================================
    // parallel word, bit 0 is red[0]
    typedef struct packed {
        logic                      pixel_valid;
        logic                      frame_sync;
        logic                      line_sync;
        logic [`LPD_COLOR_W-1:0]   blue;
        logic [`LPD_COLOR_W-1:0]   green;
        logic [`LPD_COLOR_W-1:0]   red;
    } lpd_word_t;

    typedef enum logic [1:0] {
        LPD_HUNT   = 2'h0,
        LPD_LOCKED = 2'h1,
        LPD_ASLEEP = 2'h2
    } lpd_rx_state_t;

    // ==================================================================
    // one table for sender and receiver: word bit carried by lane, slot
    function automatic logic [`LPD_BIT_IDX_W-1:0] lpd_bit_pos(
        input logic [`LPD_LANE_IDX_W-1:0] lane,
        input logic [`LPD_SLOT_IDX_W-1:0] slot
    );
        logic [`LPD_BIT_IDX_W-1:0] base;
        base = 5'h00;
        if (lane == 2'h1)
        begin
            base = 5'h07;
        end
        else if (lane == 2'h2)
        begin
            base = 5'h0E;
        end
        return base + {2'h0, slot};
    endfunction : lpd_bit_pos

endpackage : lpd_pkg

// ==== rtl/lpd_link_if.sv ====
// serial link between serializer and deserializer
`timescale 1ns/10ps
`include "lpd_consts.svh"

interface lpd_link_if;
    logic [`LPD_LANES-1:0] serial_lane;
    logic                  forwarded_clock;

    modport tx (
        output serial_lane,
        output forwarded_clock
    );

    modport rx (
        input  serial_lane,
        input  forwarded_clock
    );
endinterface : lpd_link_if

// ==== rtl/lpd_tx.sv ====
// serializer end: splits each word over three lanes, forwards the clock
`timescale 1ns/10ps
`include "lpd_consts.svh"

module lpd_tx (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        clk_en,
    // user side
    input  lpd_pkg::lpd_word_t source_word,
    output logic             word_taken,
    // link
    lpd_link_if.tx           link
);
    import lpd_pkg::*;

    // ==================================================================
    // slot timing
    logic [`LPD_SLOT_IDX_W-1:0] cyc_ff;
    logic [`LPD_SLOT_IDX_W-1:0] slot_ff;
    logic [`LPD_SLOT_IDX_W-1:0] nxt_slot;
    logic                       last_cyc;
    lpd_word_t                  word_ff;
    lpd_word_t                  nxt_word;
    logic [`LPD_LANES-1:0]      lane_ff;
    logic                       lclk_ff;
    logic                       taken_ff;

    assign last_cyc = (cyc_ff == 3'(`LPD_SLOT_CYC - 1));
    assign nxt_slot = (slot_ff == 3'(`LPD_SLOTS - 1)) ? 3'h0 : slot_ff + 3'h1; // RULE13
    assign nxt_word = (nxt_slot == 3'h0) ? source_word : word_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_ff  <= 3'(`LPD_SLOT_CYC - 1);
            slot_ff <= 3'(`LPD_SLOTS - 1);
        end
        else if (clk_en)
        begin
            cyc_ff <= last_cyc ? 3'h0 : cyc_ff + 3'h1;
            if (last_cyc)
            begin
                slot_ff <= nxt_slot;
            end
        end
    end

    // ==================================================================
    // word capture, one whole word per link clock period
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            word_ff  <= '0;
            taken_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            taken_ff <= last_cyc && (nxt_slot == 3'h0); // RULE5
            if (last_cyc && (nxt_slot == 3'h0))
            begin
                word_ff <= source_word;
            end
        end
    end

    // ==================================================================
    // lane and forwarded clock drivers, both from the same slot counter
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lane_ff <= '0;
            lclk_ff <= 1'b0;
        end
        else if (clk_en && last_cyc)
        begin
            for (int l = 0; l < `LPD_LANES; l++)
            begin
                lane_ff[l] <= nxt_word[lpd_bit_pos(2'(l), nxt_slot)]; // RULE7 RULE14 RULE6
            end
            lclk_ff <= (nxt_slot < 3'(`LPD_CLK_HI_SLOTS)); // RULE8
        end
    end

    assign word_taken           = taken_ff;
    assign link.serial_lane     = lane_ff;
    assign link.forwarded_clock = lclk_ff;

endmodule : lpd_tx

// ==== rtl/lpd_rx.sv ====
// deserializer end: recovers 21-bit words from three lanes and a clock
// Contract
// [RULE1] three data lanes plus separate forwarded clock
// [RULE2] drive 21 outputs: 18 colour, three sync
// [RULE3] regenerated clock rising edge marks captures
// [RULE4] power-down low freezes every parallel output
// [RULE5] one whole word per link clock cycle
// [RULE6] lanes carry seven bits per clock
// [RULE7] sender splits each word over three lanes
// [RULE8] sender forwards a clock locked to data
// [RULE9] output clock follows link, bounded period range
// [RULE10] lock within 10 ms, outputs invalid before
// [RULE11] enter holding state within one microsecond
// [RULE12] sample each bit at its slot centre
// [RULE13] seven evenly spaced slots per period
// [RULE14] single shared lane and slot bit table
// [RULE15] after wake wait lock and alignment first
`timescale 1ns/10ps
`include "lpd_consts.svh"

module lpd_rx #(
    parameter int unsigned LOCK_TIMEOUT_CYC = `LPD_LOCK_CYC
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst_n,
    input  wire logic          clk_en,
    // link
    lpd_link_if.rx             link,
    // panel side
    input  wire logic          sleep_hold_n,
    output lpd_pkg::lpd_word_t parallel_word_out,
    output logic               regenerated_clock_out,
    output logic               pixel_strobe_out,
    // status
    output logic               pll_locked,
    output logic               lock_timeout,
    output logic               asleep
);
    import lpd_pkg::*;

    // ==================================================================
    // pin synchronisers, bit 3 is the forwarded clock
    logic [`LPD_LANES:0] pin_raw;
    logic [`LPD_LANES:0] pin_flt;

    assign pin_raw = {link.forwarded_clock, link.serial_lane}; // RULE1

    genvar g;
    generate
        for (g = 0; g <= `LPD_LANES; g++)
        begin : g_sync
            logic s1_ff;
            logic s2_ff;
            logic s3_ff;
            logic flt_ff;
            always_ff @(posedge clock or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    s1_ff  <= 1'b0;
                    s2_ff  <= 1'b0;
                    s3_ff  <= 1'b0;
                    flt_ff <= 1'b0;
                end
                else if (clk_en)
                begin
                    s1_ff <= pin_raw[g];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    if (s2_ff == s3_ff)
                    begin
                        flt_ff <= s3_ff;
                    end
                end
            end
            assign pin_flt[g] = flt_ff;
        end
    endgenerate

    // ==================================================================
    // link clock edge and period measurement
    logic                       lclk_prev_ff;
    logic                       rise;
    logic [`LPD_CNT_W-1:0]      cnt_ff;
    logic [`LPD_CNT_W-1:0]      per_ff;
    logic                       in_range;
    logic                       match;
    logic [`LPD_SLOT_IDX_W-1:0] lock_cnt_ff;
    lpd_rx_state_t              state_ff;
    lpd_rx_state_t              nxt_state;

    assign rise     = pin_flt[`LPD_LANES] && !lclk_prev_ff;
    assign in_range = (cnt_ff >= 8'(`LPD_PER_MIN)) && (cnt_ff <= 8'(`LPD_PER_MAX)); // RULE9
    assign match    = (cnt_ff <= per_ff + 8'h01) && (cnt_ff + 8'h01 >= per_ff);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lclk_prev_ff <= 1'b0;
            cnt_ff       <= 8'h00;
            per_ff       <= 8'h00;
        end
        else if (clk_en)
        begin
            lclk_prev_ff <= pin_flt[`LPD_LANES];
            if (rise)
            begin
                cnt_ff <= 8'h01;
                per_ff <= cnt_ff;
            end
            else if (cnt_ff != 8'hFF)
            begin
                cnt_ff <= cnt_ff + 8'h01;
            end
        end
    end

    // ==================================================================
    // lock tracking: several in-range periods in a row, each within one cycle of the one before
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lock_cnt_ff <= 3'h0;
        end
        else if (clk_en)
        begin
            if (state_ff == LPD_ASLEEP || !sleep_hold_n)
            begin
                lock_cnt_ff <= 3'h0; // RULE15
            end
            else if (cnt_ff > 8'(`LPD_PER_MAX))
            begin
                lock_cnt_ff <= 3'h0;
            end
            else if (rise)
            begin
                if (!(in_range && match))
                begin
                    lock_cnt_ff <= 3'h0;
                end
                else if (lock_cnt_ff != 3'(`LPD_LOCK_EDGES))
                begin
                    lock_cnt_ff <= lock_cnt_ff + 3'h1; // RULE10
                end
            end
        end
    end

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            LPD_HUNT:
            begin
                if (!sleep_hold_n)
                begin
                    nxt_state = LPD_ASLEEP;
                end
                else if (lock_cnt_ff == 3'(`LPD_LOCK_EDGES))
                begin
                    nxt_state = LPD_LOCKED;
                end
            end
            LPD_LOCKED:
            begin
                if (!sleep_hold_n)
                begin
                    nxt_state = LPD_ASLEEP; // RULE11
                end
                else if (lock_cnt_ff != 3'(`LPD_LOCK_EDGES))
                begin
                    nxt_state = LPD_HUNT;
                end
            end
            LPD_ASLEEP:
            begin
                if (sleep_hold_n)
                begin
                    nxt_state = LPD_HUNT; // RULE15
                end
            end
            default:
            begin
                nxt_state = LPD_HUNT;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= LPD_HUNT;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
        end
    end

    // ==================================================================
    // slot sampling at slot centres: elapsed*14 >= period*(2k+1)
    logic [`LPD_ACC_W-1:0]      acc_ff;
    logic [`LPD_ACC_W-1:0]      thr_ff;
    logic [`LPD_SLOT_IDX_W-1:0] slot_ff;
    logic                       take;
    logic                       word_ok_ff;
    lpd_word_t                  asm_ff;
    logic                       publish;

    assign take    = !rise && (slot_ff < 3'(`LPD_SLOTS)) && (acc_ff >= thr_ff);
    assign publish = take && (slot_ff == 3'(`LPD_SLOTS - 1)) && word_ok_ff
                     && (state_ff == LPD_LOCKED) && sleep_hold_n; // RULE4 RULE10 RULE15

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc_ff     <= '0;
            thr_ff     <= '0;
            slot_ff    <= 3'(`LPD_SLOTS);
            word_ok_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            if (rise)
            begin
                // the seen rise is already one cycle old, so start one step in
                acc_ff     <= `LPD_ACC_W'(`LPD_ACC_STEP); // RULE12
                thr_ff     <= `LPD_ACC_W'(cnt_ff); // RULE12
                slot_ff    <= 3'h0;
                word_ok_ff <= (state_ff == LPD_LOCKED); // RULE15
            end
            else if (slot_ff < 3'(`LPD_SLOTS))
            begin
                acc_ff <= acc_ff + `LPD_ACC_W'(`LPD_ACC_STEP);
                if (take)
                begin
                    thr_ff  <= thr_ff + (`LPD_ACC_W'(per_ff) << 1); // RULE13
                    slot_ff <= slot_ff + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            asm_ff <= '0;
        end
        else if (clk_en && take)
        begin
            for (int l = 0; l < `LPD_LANES; l++)
            begin
                asm_ff[lpd_bit_pos(2'(l), slot_ff)] <= pin_flt[l]; // RULE14 RULE6
            end
        end
    end

    // ==================================================================
    // output word and regenerated clock, frozen while asleep
    lpd_word_t             out_ff;
    logic                  rclk_ff;
    logic                  strobe_ff;
    logic [`LPD_CNT_W-1:0] half_ff;
    lpd_word_t             last_word;

    always_comb
    begin
        last_word = asm_ff;
        for (int l = 0; l < `LPD_LANES; l++)
        begin
            last_word[lpd_bit_pos(2'(l), slot_ff)] = pin_flt[l];
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            out_ff    <= '0;
            rclk_ff   <= 1'b1;
            strobe_ff <= 1'b0;
            half_ff   <= 8'h00;
        end
        else if (clk_en)
        begin
            strobe_ff <= 1'b0;
            if (publish)
            begin
                out_ff  <= last_word; // RULE5 RULE2
                rclk_ff <= 1'b0;
                half_ff <= per_ff >> 1; // RULE9
            end
            // no strobe once lock is lost or power-down is requested
            else if (!rclk_ff && state_ff == LPD_LOCKED && sleep_hold_n) // RULE3 RULE4
            begin
                if (half_ff <= 8'h01)
                begin
                    rclk_ff   <= 1'b1; // RULE3
                    strobe_ff <= 1'b1;
                end
                else
                begin
                    half_ff <= half_ff - 8'h01;
                end
            end
        end
    end

    // ==================================================================
    // lock watchdog
    logic [31:0] tmo_ff;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tmo_ff <= 32'h0;
        end
        else if (clk_en)
        begin
            if (state_ff != LPD_HUNT)
            begin
                tmo_ff <= 32'h0;
            end
            else if (tmo_ff < LOCK_TIMEOUT_CYC)
            begin
                tmo_ff <= tmo_ff + 32'h1; // RULE10
            end
        end
    end

    assign parallel_word_out     = out_ff;
    assign regenerated_clock_out = rclk_ff;
    assign pixel_strobe_out      = strobe_ff;
    assign pll_locked            = (state_ff == LPD_LOCKED);
    assign lock_timeout          = (tmo_ff >= LOCK_TIMEOUT_CYC);
    assign asleep                = (state_ff == LPD_ASLEEP);

endmodule : lpd_rx

// ==== bench/lpd_link_props.sv ====
// concurrent checks on the serial link wires between the two ends
`timescale 1ns/10ps
`include "lpd_consts.svh"

module lpd_link_props (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  clk_en,
    // link wires
    input wire logic [`LPD_LANES-1:0] serial_lane,
    input wire logic                  forwarded_clock
);
    // ==================================================================
    // one clock domain
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n || !clk_en);

    // ==================================================================
    // link clock shape
    a_clock_high_time: assert property ($rose(forwarded_clock) |-> forwarded_clock[*8] ##1 !forwarded_clock)
        else $error("forwarded clock high time is not four slots");
    a_clock_low_time: assert property ($fell(forwarded_clock) |-> !forwarded_clock[*6] ##1 forwarded_clock)
        else $error("forwarded clock low time is not three slots");
    a_period_fourteen: assert property ($rose(forwarded_clock) |-> ##14 $rose(forwarded_clock))
        else $error("link period is not seven slots");
    a_fall_after_rise: assert property ($fell(forwarded_clock) |-> $past(forwarded_clock, 8) && !$past(forwarded_clock, 9))
        else $error("forwarded clock fell at the wrong slot");
    a_low_bounded: assert property (!forwarded_clock |-> ##[1:6] forwarded_clock)
        else $error("forwarded clock stayed low too long");

    // ==================================================================
    // lane slots
    a_lane_slot_hold: assert property ($rose(forwarded_clock) |-> ##1 $stable(serial_lane)
        ##2 $stable(serial_lane) ##2 $stable(serial_lane) ##2 $stable(serial_lane)
        ##2 $stable(serial_lane) ##2 $stable(serial_lane) ##2 $stable(serial_lane))
        else $error("lane changed inside a slot");
    a_lane_two_cycles: assert property ($changed(serial_lane) |=> $stable(serial_lane))
        else $error("lane slot shorter than two cycles");
    a_clock_lane_align: assert property ($changed(forwarded_clock) |=> $stable(serial_lane))
        else $error("forwarded clock edge not on a slot boundary");

    c_clock_rise: cover property ($rose(forwarded_clock));
    c_clock_fall: cover property ($fell(forwarded_clock));
    c_lane_change: cover property ($changed(serial_lane));
endmodule : lpd_link_props

// ==== bench/lvds_pixel_deserializer_tb.sv ====
// self-checking bench: serializer and deserializer face to face
`timescale 1ns/10ps
`include "lpd_consts.svh"

module lvds_pixel_deserializer_tb;
    import lpd_pkg::*;
    logic      clock;
    logic      rst_n;
    logic      clk_en;
    logic      sleep_hold_n;
    lpd_word_t source_word;
    logic      word_taken;
    lpd_word_t rx_word;
    logic      rx_clk;
    logic      rx_strobe;
    logic      rx_locked;
    logic      rx_timeout;
    logic      rx_asleep;
    lpd_word_t bad_word;
    logic      bad_locked;
    logic      bad_timeout;
    lpd_word_t notes[$];
    lpd_word_t held;
    logic      resync;
    int        gap;
    int        n_fail;
    int        num_checks;
    integer    seed;

    // ==================================================================
    // ends under test, plus a receiver fed by a clock out of range
    lpd_link_if link_ok();
    lpd_link_if link_bad();
    lpd_tx i_lpd_tx (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .source_word(source_word),
        .word_taken(word_taken), .link(link_ok));
    lpd_rx #(.LOCK_TIMEOUT_CYC(200)) i_lpd_rx (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .link(link_ok), .sleep_hold_n(sleep_hold_n), .parallel_word_out(rx_word),
        .regenerated_clock_out(rx_clk), .pixel_strobe_out(rx_strobe), .pll_locked(rx_locked),
        .lock_timeout(rx_timeout), .asleep(rx_asleep));
    lpd_rx #(.LOCK_TIMEOUT_CYC(200)) i_lpd_rx_bad (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .link(link_bad), .sleep_hold_n(1'b1), .parallel_word_out(bad_word),
        .regenerated_clock_out(), .pixel_strobe_out(), .pll_locked(bad_locked),
        .lock_timeout(bad_timeout), .asleep());
    lpd_link_props i_lpd_link_props (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
        .serial_lane(link_ok.serial_lane), .forwarded_clock(link_ok.forwarded_clock));

    // ==================================================================
    // shared tasks
    task automatic check(input string what, input logic [20:0] exp, input logic [20:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_high(input string what, ref logic sig, input int limit);
        int i;
        for (i = 0; i < limit && sig !== 1'b1; i++)
            @(negedge clock);
        check(what, 21'h1, {20'h0, sig});
        if (sig !== 1'b1)
            tally_and_finish();
    endtask : wait_high

    // ==================================================================
    // clocks: system clock and the faulty link clock, 800 ns period
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    initial
    begin
        link_bad.serial_lane = 3'h0;
        link_bad.forwarded_clock = 1'b0;
        forever #400 link_bad.forwarded_clock = ~link_bad.forwarded_clock;
    end

    always @(negedge clock)
        link_bad.serial_lane <= ~link_bad.serial_lane;

    // ==================================================================
    // driver: notes each taken word and checks its lane slots
    always
    begin : drive
        lpd_word_t w;
        integer    rnd;
        int        k;
        @(negedge clock);
        if (rst_n === 1'b1 && word_taken === 1'b1)
        begin
            w = source_word;
            notes.push_back(w);
            rnd = $random(seed);
            source_word = lpd_word_t'(rnd[20:0]);
            for (k = 0; k < `LPD_SLOTS; k++)
            begin
                check("lanes", {18'h0, w[14+k], w[7+k], w[k]}, {18'h0, link_ok.serial_lane});
                check("fwd clock", {20'h0, k < 4}, {20'h0, link_ok.forwarded_clock});
                if (k < `LPD_SLOTS - 1)
                    repeat (2) @(negedge clock);
            end
        end
    end

    // ==================================================================
    // monitor: each strobe takes the oldest note, or after a resync the oldest one equal to the word
    always @(negedge clock)
    begin
        gap++;
        if (rx_strobe === 1'b1)
        begin
            while (resync && notes.size() > 0 && notes[0] !== rx_word)
                void'(notes.pop_front());
            if (!resync)
                check("strobe gap", 21'h0E, gap[20:0]);
            check("strobe level", 21'h1, {20'h0, rx_clk});
            check("strobe locked", 21'h1, {20'h0, rx_locked});
            check("word", (notes.size() > 0) ? notes.pop_front() : ~rx_word, rx_word);
            resync = 1'b0;
            gap = 0;
        end
    end

    // ==================================================================
    // main sequence
    initial
    begin
        seed = 79188;
        n_fail = 0;
        num_checks = 0;
        gap = 0;
        resync = 1'b1;
        rst_n = 1'b0;
        clk_en = 1'b0;
        sleep_hold_n = 1'b1;
        source_word = lpd_word_t'(21'h0);
        repeat (2) @(negedge clock);
        rst_n = 1'b1;
        // clock enable low: the sender must not start a word
        repeat (20)
        begin
            @(negedge clock);
            check("frozen tx", 21'h0, {20'h0, word_taken});
        end
        clk_en = 1'b1;
        wait_high("pll_locked", rx_locked, 300);
        repeat (120) @(negedge clock);
        sleep_hold_n = 1'b0;
        wait_high("asleep", rx_asleep, `LPD_PDN_CYC);
        held = rx_word;
        repeat (60)
        begin
            @(negedge clock);
            check("frozen word", held, rx_word);
        end
        sleep_hold_n = 1'b1;
        resync = 1'b1;
        repeat (2) @(negedge clock);
        check("relock pending", 21'h0, {20'h0, rx_locked});
        wait_high("pll_locked", rx_locked, 300);
        repeat (120) @(negedge clock);
        check("bad lock", 21'h0, {20'h0, bad_locked});
        check("bad timeout", 21'h1, {20'h0, bad_timeout});
        check("bad word", 21'h0, bad_word);
        check("good timeout", 21'h0, {20'h0, rx_timeout});
        tally_and_finish();
    end

    initial
    begin
        repeat (5000) @(posedge clock);
        check("run time", 21'h0, 21'h1);
        tally_and_finish();
    end
endmodule : lvds_pixel_deserializer_tb
